// >>> rtl/srpc_pkg.sv
// Constants, register map and state codes of the suspend and resume power controller
// What this block does
// - Main 30, 48 and 60 MHz clocks come from one 12 MHz reference
// - In suspend main clocks stop; only the slow keep-alive clock runs
// - Port connect or disconnect, chip access or low wake pin start resume
// - Wake pin driven low while awake; floats high while suspended
// - In suspend a high wake pin does nothing; low starts wake-up
// - Resume state held for clock-off count in power-down bits 31..16, default 10 ms
// - Run bit set during hold gives normal operation, else back to suspend
// - Clock-off count reaches hold times of about 500 ms or more
// - Power-down register holds per-block disable bits for the main clocks
// - Clocks-ready raised within 100 us of the wake event
// - With power kept on, wake to suspend takes about 100 ms
package srpc_pkg;

	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int REF_CLK_MHZ = 12;
	localparam int KEEPALIVE_HZ = 100_000;
	localparam int KEEPALIVE_DIV = CLK_HZ / KEEPALIVE_HZ;
	localparam int MS_PER_S = 1000;

	// Resume hold and suspend entry, counted in keep-alive ticks
	localparam int CLKOFF_DEFAULT_MS = 10;
	localparam logic [15:0] CLKOFF_RESET = 16'(CLKOFF_DEFAULT_MS * (KEEPALIVE_HZ / MS_PER_S));
	localparam int SUSPEND_DELAY_MS = 100;
	localparam int SUSPEND_TICKS_DEF = SUSPEND_DELAY_MS * (KEEPALIVE_HZ / MS_PER_S);

	// PLL restart time, least time rounded up to cycles
	localparam int PLL_LOCK_NS = 50_000;
	localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] PLL_LOCK_LAST = 12'(PLL_LOCK_CYC - 1);

	// Byte addresses on the register bus
	localparam logic [3:0] REG_PWRDN = 4'h0;
	localparam logic [3:0] REG_CMD = 4'h4;
	localparam logic [3:0] REG_STAT = 4'h8;

	// Field positions
	localparam int CLKOFF_LSB = 16;
	localparam int CLKOFF_MSB = 31;
	localparam int DIS_CLK30_BIT = 0;
	localparam int DIS_CLK48_BIT = 1;
	localparam int DIS_CLK60_BIT = 2;
	localparam int BLKDIS_MSB = 2;
	localparam int RUN_BIT = 0;
	localparam int STAT_STATE_MSB = 2;
	localparam int STAT_READY_BIT = 4;
	localparam int STAT_AWAKE_BIT = 5;
	localparam logic [2:0] BLKDIS_RESET = 3'h0;

	typedef enum logic [2:0] {
		ST_AWAKE = 3'h0,
		ST_SUSP_ENTRY = 3'h1,
		ST_SUSPENDED = 3'h2,
		ST_WAKE_LOCK = 3'h3,
		ST_RESUME_HOLD = 3'h4
	} srpc_state_e;

	// Merge bus write data into a register under byte enables
	function automatic logic [31:0] srpc_merge(input logic [31:0] old, input logic [31:0] wdata,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return res;
	endfunction : srpc_merge

endpackage : srpc_pkg

// >>> rtl/srpc_tick_div.sv
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module srpc_tick_div #(
	parameter int DIV = 500
) (
	input wire logic i_clk,
	input wire logic i_reset,
	output logic o_tick
);
	localparam int W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	localparam logic [W-1:0] ZERO = '0;

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic tick_nxt;

	always_comb begin
		tick_nxt = (cnt_r == LAST);
		cnt_nxt = tick_nxt ? ZERO : cnt_r + W'(1);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cnt_r <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			o_tick <= tick_nxt;
		end
	end

endmodule : srpc_tick_div

// >>> rtl/srpc_top.sv
// Suspend and resume power controller with Avalon-MM register slave
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module srpc_top #(
	parameter logic [15:0] P_SUSPEND_TICKS = 16'(srpc_pkg::SUSPEND_TICKS_DEF)
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_suspend_wake_pin_i,
	output logic o_suspend_wake_pin_o,
	output logic o_suspend_wake_pin_oe_n,
	input wire logic i_port_connect,
	output logic o_pll_en,
	output logic o_clk30_run,
	output logic o_clk48_run,
	output logic o_clk60_run,
	output logic o_keepalive_tick,
	output logic o_clocks_ready_irq,
	output logic o_awake
);
	import srpc_pkg::*;

	// Keep-alive tick, the only time base left in suspend
	srpc_tick_div #(
		.DIV(KEEPALIVE_DIV)
	) u_keepalive (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.o_tick(o_keepalive_tick)
	);

	// Pin synchronisers
	logic pin_s1_r, pin_s2_r, port_s1_r, port_s2_r, port_s3_r;
	// Pin release, delayed to line up with the synchronised pin level
	logic rel_d1_r, rel_d2_r;
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			port_s1_r <= 1'b0;
			port_s2_r <= 1'b0;
			port_s3_r <= 1'b0;
			rel_d1_r <= 1'b0;
			rel_d2_r <= 1'b0;
		end else begin
			pin_s1_r <= i_suspend_wake_pin_i;
			pin_s2_r <= pin_s1_r;
			port_s1_r <= i_port_connect;
			port_s2_r <= port_s1_r;
			port_s3_r <= port_s2_r;
			rel_d1_r <= o_suspend_wake_pin_oe_n;
			rel_d2_r <= rel_d1_r;
		end
	end

	srpc_state_e state_r, state_nxt;
	logic [15:0] clkoff_r, clkoff_nxt;
	logic [2:0] blkdis_r, blkdis_nxt;
	logic run_r, run_nxt;
	logic ready_r, ready_nxt;
	logic pend_r, pend_nxt;
	logic [15:0] hold_cnt_r, hold_cnt_nxt;
	logic [15:0] susp_cnt_r, susp_cnt_nxt;
	logic [11:0] lock_cnt_r, lock_cnt_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdata_nxt;
	logic pll_nxt, gate_nxt, oe_n_nxt;
	logic req, clocks_on, wake_now, wr_pwrdn, wr_cmd, clr_ready, set_ready;
	logic [31:0] pwrdn_word, cmd_word, stat_word, merged;

	always_comb begin
		req = i_avs_read | i_avs_write;
		clocks_on = (state_r == ST_AWAKE) || (state_r == ST_SUSP_ENTRY) || (state_r == ST_RESUME_HOLD);
		// Wake sources; a bus access stands for chip select
		// Own low drive still in the synchroniser after release is no wake
		wake_now = (!pin_s2_r && rel_d2_r) || (port_s2_r != port_s3_r) || req;
		pwrdn_word = '0;
		pwrdn_word[CLKOFF_MSB:CLKOFF_LSB] = clkoff_r;
		pwrdn_word[BLKDIS_MSB:0] = blkdis_r;
		cmd_word = '0;
		cmd_word[RUN_BIT] = run_r;
		stat_word = '0;
		stat_word[STAT_STATE_MSB:0] = state_r;
		stat_word[STAT_READY_BIT] = ready_r;
		stat_word[STAT_AWAKE_BIT] = !o_suspend_wake_pin_oe_n;
		// Access completes only while main clocks run
		ack_nxt = req && !ack_r && clocks_on;
		rdata_nxt = o_avs_readdata;
		if (ack_nxt && i_avs_read) begin
			unique case (i_avs_address)
				REG_PWRDN: rdata_nxt = pwrdn_word;
				REG_CMD: rdata_nxt = cmd_word;
				REG_STAT: rdata_nxt = stat_word;
				default: rdata_nxt = '0;
			endcase
		end
		wr_pwrdn = ack_r && i_avs_write && (i_avs_address == REG_PWRDN);
		wr_cmd = ack_r && i_avs_write && (i_avs_address == REG_CMD);
		clr_ready = ack_r && i_avs_write && (i_avs_address == REG_STAT)
			&& i_avs_byteenable[0] && i_avs_writedata[STAT_READY_BIT];
		merged = srpc_merge(pwrdn_word, i_avs_writedata, i_avs_byteenable);
		clkoff_nxt = wr_pwrdn ? merged[CLKOFF_MSB:CLKOFF_LSB] : clkoff_r;
		blkdis_nxt = wr_pwrdn ? merged[BLKDIS_MSB:0] : blkdis_r;
		run_nxt = (wr_cmd && i_avs_byteenable[0]) ? i_avs_writedata[RUN_BIT] : run_r;
	end

	// Power state machine
	always_comb begin
		state_nxt = state_r;
		hold_cnt_nxt = hold_cnt_r;
		susp_cnt_nxt = susp_cnt_r;
		lock_cnt_nxt = lock_cnt_r;
		pend_nxt = 1'b0;
		set_ready = 1'b0;
		unique case (state_r)
			ST_AWAKE: begin
				if (!run_r) begin
					state_nxt = ST_SUSP_ENTRY;
					susp_cnt_nxt = P_SUSPEND_TICKS;
				end
			end
			ST_SUSP_ENTRY: begin
				if (run_r) begin
					state_nxt = ST_AWAKE;
				end else if (o_keepalive_tick) begin
					if (susp_cnt_r == '0) begin
						state_nxt = ST_SUSPENDED;
					end else begin
						susp_cnt_nxt = susp_cnt_r - 16'h0001;
					end
				end
			end
			ST_SUSPENDED: begin
				// Wake events caught between ticks, acted on at a tick
				pend_nxt = pend_r || wake_now;
				if (o_keepalive_tick && (pend_r || wake_now)) begin
					state_nxt = ST_WAKE_LOCK;
					lock_cnt_nxt = '0;
					pend_nxt = 1'b0;
				end
			end
			ST_WAKE_LOCK: begin
				if (lock_cnt_r == PLL_LOCK_LAST) begin
					state_nxt = ST_RESUME_HOLD;
					hold_cnt_nxt = clkoff_r;
					set_ready = 1'b1;
				end else begin
					lock_cnt_nxt = lock_cnt_r + 12'h001;
				end
			end
			ST_RESUME_HOLD: begin
				if (run_r) begin
					state_nxt = ST_AWAKE;
				end else if (o_keepalive_tick) begin
					if (hold_cnt_r == '0) begin
						state_nxt = ST_SUSPENDED;
					end else begin
						hold_cnt_nxt = hold_cnt_r - 16'h0001;
					end
				end
			end
			default: state_nxt = ST_SUSPENDED;
		endcase
		// Set wins over a clear in the same cycle
		ready_nxt = set_ready || (ready_r && !clr_ready);
		pll_nxt = (state_nxt != ST_SUSPENDED);
		gate_nxt = (state_nxt == ST_AWAKE) || (state_nxt == ST_SUSP_ENTRY) || (state_nxt == ST_RESUME_HOLD);
		oe_n_nxt = (state_nxt == ST_SUSPENDED);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= ST_AWAKE;
			clkoff_r <= CLKOFF_RESET;
			blkdis_r <= BLKDIS_RESET;
			run_r <= 1'b0;
			ready_r <= 1'b0;
			pend_r <= 1'b0;
			hold_cnt_r <= '0;
			susp_cnt_r <= '0;
			lock_cnt_r <= '0;
			ack_r <= 1'b0;
			o_avs_readdata <= '0;
			o_avs_waitrequest <= 1'b1;
			o_suspend_wake_pin_o <= 1'b0;
			o_suspend_wake_pin_oe_n <= 1'b0;
			o_pll_en <= 1'b1;
			o_clk30_run <= 1'b0;
			o_clk48_run <= 1'b0;
			o_clk60_run <= 1'b0;
			o_clocks_ready_irq <= 1'b0;
			o_awake <= 1'b1;
		end else begin
			state_r <= state_nxt;
			clkoff_r <= clkoff_nxt;
			blkdis_r <= blkdis_nxt;
			run_r <= run_nxt;
			ready_r <= ready_nxt;
			pend_r <= pend_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			susp_cnt_r <= susp_cnt_nxt;
			lock_cnt_r <= lock_cnt_nxt;
			ack_r <= ack_nxt;
			o_avs_readdata <= rdata_nxt;
			o_avs_waitrequest <= !ack_nxt;
			o_suspend_wake_pin_o <= 1'b0;
			o_suspend_wake_pin_oe_n <= oe_n_nxt;
			o_pll_en <= pll_nxt;
			o_clk30_run <= gate_nxt && !blkdis_nxt[DIS_CLK30_BIT];
			o_clk48_run <= gate_nxt && !blkdis_nxt[DIS_CLK48_BIT];
			o_clk60_run <= gate_nxt && !blkdis_nxt[DIS_CLK60_BIT];
			o_clocks_ready_irq <= ready_nxt;
			o_awake <= !oe_n_nxt;
		end
	end

	// Checks
	localparam int KA_MAX = KEEPALIVE_DIV;

	// Cycles spent waiting for lock, for the clocks-ready deadline
	logic [11:0] lock_age_r, lock_age_nxt;
	always_comb begin
		lock_age_nxt = '0;
		if (state_r == ST_WAKE_LOCK) begin
			lock_age_nxt = lock_age_r + 12'h001;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			lock_age_r <= '0;
		end else begin
			lock_age_r <= lock_age_nxt;
		end
	end

	property p_pin_state;
		@(posedge i_clk) disable iff (i_reset)
		o_suspend_wake_pin_oe_n == (state_r == ST_SUSPENDED) && !o_suspend_wake_pin_o;
	endproperty
	a_pin_state: assert property (p_pin_state) else $error("wake pin drive does not match state");

	property p_tick_period;
		@(posedge i_clk) disable iff (i_reset)
		o_keepalive_tick |=> !o_keepalive_tick [*8] ##[1:KA_MAX] o_keepalive_tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("keep-alive tick period wrong");

	property p_clocks_off;
		@(posedge i_clk) disable iff (i_reset)
		(state_r == ST_SUSPENDED) |-> !o_clk30_run && !o_clk48_run && !o_clk60_run && !o_pll_en;
	endproperty
	a_clocks_off: assert property (p_clocks_off) else $error("main clocks run in suspend");

	property p_pin_wake;
		@(posedge i_clk) disable iff (i_reset)
		(state_r == ST_SUSPENDED && o_keepalive_tick && !pin_s2_r) |=> state_r == ST_WAKE_LOCK;
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("low wake pin did not wake");

	property p_no_false_wake;
		@(posedge i_clk) disable iff (i_reset)
		(state_r == ST_SUSPENDED && !pend_r && !wake_now) |=> state_r == ST_SUSPENDED;
	endproperty
	a_no_false_wake: assert property (p_no_false_wake) else $error("wake without cause");

	sequence s_wake;
		(state_r == ST_SUSPENDED) ##1 (state_r == ST_WAKE_LOCK);
	endsequence
	sequence s_lock_done;
		(state_r == ST_WAKE_LOCK) ##1 (state_r == ST_RESUME_HOLD);
	endsequence
	property p_wake_drive;
		@(posedge i_clk) disable iff (i_reset)
		s_wake |-> o_pll_en && o_awake && (lock_age_r == '0);
	endproperty
	a_wake_drive: assert property (p_wake_drive) else $error("wake did not restart clocks");
	property p_ready_time;
		@(posedge i_clk) disable iff (i_reset)
		(state_r == ST_WAKE_LOCK) |-> (lock_age_r <= PLL_LOCK_LAST);
	endproperty
	a_ready_time: assert property (p_ready_time) else $error("clocks-ready late");
	property p_ready_after_lock;
		@(posedge i_clk) disable iff (i_reset)
		s_lock_done |-> o_clocks_ready_irq && o_pll_en && (o_clk60_run || blkdis_r[DIS_CLK60_BIT]);
	endproperty
	a_ready_after_lock: assert property (p_ready_after_lock) else $error("clocks-ready missing after lock");

	property p_run_awake;
		@(posedge i_clk) disable iff (i_reset)
		(state_r == ST_RESUME_HOLD && run_r) |=> (state_r == ST_AWAKE) ##1 o_clk60_run || blkdis_r[DIS_CLK60_BIT];
	endproperty
	a_run_awake: assert property (p_run_awake) else $error("run bit did not give normal state");

	property p_hold_expire;
		@(posedge i_clk) disable iff (i_reset)
		(state_r == ST_RESUME_HOLD && !run_r && o_keepalive_tick && hold_cnt_r == '0)
			|=> (state_r == ST_SUSPENDED) ##1 o_suspend_wake_pin_oe_n;
	endproperty
	a_hold_expire: assert property (p_hold_expire) else $error("hold expiry missed");

	property p_hold_load;
		@(posedge i_clk) disable iff (i_reset)
		$rose(state_r == ST_RESUME_HOLD) |-> hold_cnt_r == clkoff_r;
	endproperty
	a_hold_load: assert property (p_hold_load) else $error("hold count not loaded");

	property p_susp_entry;
		@(posedge i_clk) disable iff (i_reset)
		(state_r == ST_SUSP_ENTRY && !run_r && o_keepalive_tick && susp_cnt_r == '0) |=> state_r == ST_SUSPENDED;
	endproperty
	a_susp_entry: assert property (p_susp_entry) else $error("suspend entry missed");

	property p_blkdis;
		@(posedge i_clk) disable iff (i_reset)
		(blkdis_r[DIS_CLK30_BIT] && $stable(blkdis_r)) |-> !o_clk30_run;
	endproperty
	a_blkdis: assert property (p_blkdis) else $error("disabled clock still runs");

endmodule : srpc_top

// >>> tb/srpc_proc_model.sv
// Processor model: GPIO with pull-up on the suspend and wake pin
`timescale 1ns/1ps
module srpc_proc_model (
	input wire logic i_clk,
	input wire logic i_gpio_low,
	input wire logic i_dev_o,
	input wire logic i_dev_oe_n,
	output logic o_pin
);
	logic gpio_low_r;
	always_ff @(posedge i_clk) begin
		gpio_low_r <= i_gpio_low;
	end
	// Pull-up wins unless a party drives
	always_comb begin
		o_pin = 1'b1;
		if (!i_dev_oe_n) begin
			o_pin = i_dev_o;
		end else if (gpio_low_r) begin
			o_pin = 1'b0;
		end
	end
endmodule : srpc_proc_model

// >>> tb/suspend_resume_power_ctl_bench.sv
// Self-checking bench of the suspend and resume power controller
`timescale 1ns/1ps
module suspend_resume_power_ctl_bench;
	import srpc_pkg::*;
	localparam int SUSP_TICKS = 4;
	localparam int TICK = KEEPALIVE_DIV;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic gpio_low = 1'b0;
	logic port = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] got;
	logic pin, wq, oe_n, pin_o, pll_en, c30, c48, c60, tick, irq, awake;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	int seed = 32'h879C;
	int n;
	int t0;
	localparam int HYB_RESET_CYC = 100;
	int m_cnt = 1000;
	int m_dis = 0;
	always #10 clk = ~clk;
	srpc_top #(.P_SUSPEND_TICKS(16'(SUSP_TICKS))) i_srpc_top (.i_clk(clk), .i_reset(rst), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_suspend_wake_pin_i(pin),
		.o_suspend_wake_pin_o(pin_o), .o_suspend_wake_pin_oe_n(oe_n), .i_port_connect(port),
		.o_pll_en(pll_en), .o_clk30_run(c30), .o_clk48_run(c48), .o_clk60_run(c60),
		.o_keepalive_tick(tick), .o_clocks_ready_irq(irq), .o_awake(awake));
	srpc_proc_model i_srpc_proc_model (.i_clk(clk), .i_gpio_low(gpio_low), .i_dev_o(pin_o),
		.i_dev_oe_n(oe_n), .o_pin(pin));
	function automatic logic [31:0] pw();
		return {m_cnt[15:0], 13'h0, m_dis[2:0]};
	endfunction : pw
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		be <= b;
		do @(posedge clk); while (wq !== 1'b0);
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic wait_for(input bit on_irq, input logic v, output int c);
		c = 0;
		while ((on_irq ? irq : awake) !== v) begin
			@(posedge clk);
			c++;
		end
	endtask : wait_for
	task automatic conclude();
		$display("Checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		chk("waitrequest", wq, 1);
		chk("pin", pin, 0);
		chk("irq", irq, 0);
		bus(0, REG_PWRDN, 0, 4'hF);
		chk("pwrdn", got, pw());
		chk("clocks", {c60, c48, c30}, 3'h7);
		bus(0, 4'hC, 0, 4'hF);
		chk("unmapped", got, 0);
		bus(1, REG_PWRDN, 32'hFFFF_FF05, 4'h1);
		m_dis = 5;
		repeat (2) @(posedge clk);
		chk("gates", {c60, c48, c30}, 3'h2);
		bus(1, REG_PWRDN, 32'hFFFF_0000, 4'hC);
		m_cnt = 16'hFFFF;
		bus(0, REG_PWRDN, 0, 4'hF);
		chk("pwrdn", got, pw());
		m_cnt = 1 + ($unsigned($random(seed)) % 3);
		m_dis = 0;
		bus(1, REG_PWRDN, pw(), 4'hF);
		bus(0, REG_PWRDN, 0, 4'hF);
		chk("pwrdn", got, pw());
		wait_for(0, 0, n);
		chk("pll", pll_en, 0);
		chk("clocks", {c60, c48, c30}, 3'h0);
		chk("pin", pin, 1);
		gpio_low <= 1'b1;
		wait_for(1, 1, n);
		t0 = cycles;
		chk("ready_time", n <= 5000, 1);
		chk("ready_wait", n >= PLL_LOCK_CYC, 1);
		chk("awake", awake, 1);
		gpio_low <= 1'b0;
		// Clear the sticky flag so the next wake is timed afresh
		bus(1, REG_STAT, 32'h10, 4'h1);
		wait_for(0, 0, n);
		n = cycles - t0;
		chk("hold_time", n >= m_cnt * TICK && n <= (m_cnt + 1) * TICK + 2, 1);
		repeat (3 * TICK) @(posedge clk);
		chk("asleep", awake, 0);
		port <= 1'b1;
		wait_for(1, 1, n);
		chk("ready_time", n <= 5000, 1);
		chk("ready_wait", n >= PLL_LOCK_CYC, 1);
		bus(1, REG_STAT, 32'h10, 4'h1);
		bus(1, REG_CMD, 32'h1, 4'h1);
		repeat ((m_cnt + 3) * TICK) @(posedge clk);
		chk("awake", awake, 1);
		bus(0, REG_STAT, 0, 4'hF);
		chk("status", got, 32'h20);
		bus(1, REG_CMD, 32'h0, 4'h1);
		wait_for(0, 0, n);
		chk("suspend_time", n >= SUSP_TICKS * TICK && n <= (SUSP_TICKS + 2) * TICK, 1);
		bus(0, REG_STAT, 0, 4'hF);
		chk("status", {got[5], got[2:0]}, 4'hC);
		chk("pin", pin, 0);
		// Supply return after hybrid suspend, pulse scaled for simulation
		rst <= 1'b1;
		repeat (HYB_RESET_CYC) @(posedge clk);
		rst <= 1'b0;
		chk("waitrequest", wq, 1);
		chk("irq", irq, 0);
		chk("awake", awake, 1);
		m_cnt = CLKOFF_RESET;
		m_dis = 0;
		bus(0, REG_PWRDN, 0, 4'hF);
		chk("pwrdn", got, pw());
		conclude();
	end
endmodule : suspend_resume_power_ctl_bench
